// *** bench/uart_receiver_status_and_start_detect_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "urx_consts.svh"
module uart_receiver_status_and_start_detect_tb_top;
  import urx_pkg::*;
  // data, then pen podd ds stop2 bpar bstop, then expected ferr perr
  typedef struct packed {
    logic [7:0] d;
    logic [5:0] opt;
    logic ferr;
    logic perr;
  } urx_row_t;
  urx_row_t rows [9] = '{16'ha500, 16'h3c80, 16'h3cc0, 16'h5ac9, 16'h81a9,
    16'h0f16, 16'hf026, 16'h5508, 16'hffe0};
  urx_row_t r;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`URX_ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rxc_irq, claimed, tx_ready;
  logic tx_valid = 1'b0;
  logic glitch_n = 1'b1;
  logic [7:0] tx_data = 8'h00;
  logic [5:0] opt = 6'h00;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  urx_link_if link_tx ();
  urx_link_if link_rx ();
  // noise is injected on the receiver side only
  assign link_rx.serial_line = link_tx.serial_line & glitch_n;
  initial begin
    forever #5 pclk = ~pclk;
  end
  urx_receiver urx_receiver_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxc_irq(rxc_irq), .rxd_pin_claimed(claimed), .link(link_rx));
  urx_transmitter urx_transmitter_inst (.pclk(pclk), .presetn(presetn),
    .tx_valid(tx_valid), .tx_data(tx_data), .parity_enable_bit(opt[5]),
    .parity_odd_select(opt[4]), .double_speed_select(opt[3]),
    .stop_bit_count_select(opt[2]), .baud_div(16'h0001),
    .force_bad_parity(opt[1]), .force_bad_stop(opt[0]),
    .tx_ready(tx_ready), .link(link_tx));
  urx_chk urx_chk_inst (.pclk(pclk), .presetn(presetn),
    .serial_line(link_tx.serial_line), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxc_irq(rxc_irq),
    .rxd_pin_claimed(claimed), .tx_valid(tx_valid), .tx_ready(tx_ready));
  //////////////////////////////////////////////////////////////////////////
  task close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task chk_rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask : chk_rd
  task tx_go(input logic [7:0] d);
    @(posedge pclk);
    tx_data <= d;
    tx_valid <= 1'b1;
    @(posedge pclk);
    tx_valid <= 1'b0;
  endtask : tx_go
  task tx_wait();
    do begin
      @(posedge pclk);
      #1;
    end while (tx_ready !== 1'b1);
  endtask : tx_wait
  task send(input logic [7:0] d);
    tx_go(d);
    tx_wait();
  endtask : send
  //////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk_rd(`URX_CTRL_OFF, 32'h0);
    chk_rd(`URX_BAUD_OFF, 32'h0);
    chk_rd(`URX_STAT_OFF, 32'h0);
    chk_rd(`URX_DATA_OFF, 32'h0);
    chk("pins", 32'h0, {30'h0, claimed, rxc_irq});
    chk_rd(12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'b1, `URX_BAUD_OFF, 32'h1);
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, `URX_CTRL_OFF, {25'h0, 1'b1, r.opt[2], r.opt[4], r.opt[5],
        r.opt[3], 2'h3});
      opt <= r.opt;
      send(r.d);
      chk("irq", 32'h1, {31'h0, rxc_irq});
      chk_rd(`URX_STAT_OFF, {28'h0, r.perr, 1'b0, r.ferr, 1'b1});
      chk_rd(`URX_DATA_OFF, {24'h0, r.d});
      chk_rd(`URX_STAT_OFF, 32'h0);
    end
    // four frames unread: third is held, fourth overruns and is lost
    apb(1'b1, `URX_CTRL_OFF, 32'h1);
    opt <= 6'h00;
    for (int k = 1; k <= 4; k++) send(8'h11 * k);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) apb(1'b1, `URX_STAT_OFF, 32'h0);
      chk_rd(`URX_STAT_OFF, {29'h0, k == 2, 2'h1});
      chk_rd(`URX_DATA_OFF, 32'h11 * (k + 1));
    end
    chk_rd(`URX_STAT_OFF, 32'h0);
    send(8'h66);
    chk_rd(`URX_STAT_OFF, 32'h1);
    apb(1'b1, `URX_CTRL_OFF, 32'h0);
    chk_rd(`URX_STAT_OFF, 32'h0);
    chk("claimed", 32'h0, {31'h0, claimed});
    apb(1'b1, `URX_CTRL_OFF, 32'h1);
    tx_go(8'h99);
    repeat (100) @(posedge pclk);
    apb(1'b1, `URX_CTRL_OFF, 32'h0);
    tx_wait();
    apb(1'b1, `URX_CTRL_OFF, 32'h1);
    chk_rd(`URX_STAT_OFF, 32'h0);
    send(8'hc3);
    chk_rd(`URX_DATA_OFF, 32'hc3);
    // 7 ticks low is noise, 10 ticks low is a start; a frame is 320 clocks, 352 are waited
    glitch_n <= 1'b0;
    repeat (14) @(posedge pclk);
    glitch_n <= 1'b1;
    repeat (352) @(posedge pclk);
    chk_rd(`URX_STAT_OFF, 32'h0);
    glitch_n <= 1'b0;
    repeat (20) @(posedge pclk);
    glitch_n <= 1'b1;
    repeat (352) @(posedge pclk);
    chk_rd(`URX_STAT_OFF, 32'h1);
    chk_rd(`URX_DATA_OFF, 32'hff);
    close_out();
  end
endmodule : uart_receiver_status_and_start_detect_tb_top
`default_nettype wire

// *** bench/urx_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "urx_consts.svh"
module urx_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serial_line,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`URX_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxc_irq,
  input wire logic rxd_pin_claimed,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic wctl;
  logic mapped;
  logic en_w;
  logic irq_on;
  assign acc = psel && penable;
  assign wctl = acc && pwrite && paddr == `URX_CTRL_OFF;
  assign mapped = paddr[1:0] == 2'h0 && paddr < 12'h010;
  assign en_w = pwdata[`URX_C_EN];
  assign irq_on = pwdata[`URX_C_RCIRQ] && pwdata[`URX_C_GIE];
  //////////////////////////////////////////////////////////////////////////
  a_zero_wait: assert property (psel |-> pready)
    else $error("pready low during transfer");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped address");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped address");
  a_claim_follows: assert property (wctl |=> rxd_pin_claimed == $past(en_w))
    else $error("pin claim does not follow enable");
  a_irq_gated: assert property (wctl && !irq_on |-> ##2 !rxc_irq)
    else $error("irq while not enabled");
  a_flush_quiet: assert property (!rxd_pin_claimed [*4] |-> !rxc_irq)
    else $error("irq while receiver disabled");
  a_empty_flags: assert property (acc && !pwrite && paddr == `URX_STAT_OFF
    && !prdata[`URX_S_RXC] |-> prdata[3:1] == 3'h0)
    else $error("error flags set with empty buffer");
  a_start_low: assert property (tx_valid && tx_ready |=> !serial_line)
    else $error("no start bit after take");
  a_idle_high: assert property (tx_ready |-> serial_line)
    else $error("line low while idle");
  //////////////////////////////////////////////////////////////////////////
  c_claim: cover property (wctl ##1 rxd_pin_claimed);
  c_slverr: cover property (acc && pslverr);
  c_irq: cover property ($rose(rxc_irq));
endmodule : urx_chk
`default_nettype wire

// *** hdl/urx_consts.svh ***
// Behaviour
// RQ1: receive-complete flag high while buffer holds characters
// RQ2: disabling receiver flushes buffer, clears flag
// RQ3: interrupt requested while enabled and flag set
// RQ4: data read pops oldest character
// RQ5: error flags travel with each buffered character
// RQ6: writes to error flag bits are ignored
// RQ7: software writes zeros to error flag bits
// RQ8: error flags never raise an interrupt
// RQ9: frame error mirrors first stop bit
// RQ10: only first stop bit is checked
// RQ11: overrun on start with full buffer, shifter waiting
// RQ12: overrun cleared when shifter moves into buffer
// RQ13: parity checked only when enabled; odd/even select
// RQ14: parity error only if checked and failed
// RQ15: disabling receiver abandons frame at once
// RQ16: disabled receiver releases the receive pin
// RQ17: software flushes by reading data until empty
// RQ18: sample at 16x, or 8x in double speed
// RQ19: first low sample is 1; vote centre three
// RQ20: majority high rejects start as noise
// RQ21: bit phase realigned on every valid start
// RQ22: each bit decided by centre-sample majority
// RQ23: odd select zero means even parity
// RQ24: buffer is two-deep first-in first-out
`ifndef URX_CONSTS_SVH
`define URX_CONSTS_SVH

`define URX_ADDR_W 12
`define URX_CTRL_OFF 12'h000
`define URX_STAT_OFF 12'h004
`define URX_DATA_OFF 12'h008
`define URX_BAUD_OFF 12'h00c

`define URX_CTRL_W 7
`define URX_CTRL_RST 7'h00
`define URX_C_EN 0
`define URX_C_RCIRQ 1
`define URX_C_DS 2
`define URX_C_PEN 3
`define URX_C_PODD 4
`define URX_C_STOP2 5
`define URX_C_GIE 6

`define URX_S_RXC 0
`define URX_S_FERR 1
`define URX_S_DOR 2
`define URX_S_PERR 3

`define URX_BAUD_RST 16'h0000

`define URX_SPB_NORM 5'h10
`define URX_SPB_DBL 5'h08
`define URX_MID_NORM 5'h08
`define URX_MID_DBL 5'h04
`define URX_LAST_BIT 4'h7

`define URX_ENT_W 11
`define URX_E_FERR 8
`define URX_E_DOR 9
`define URX_E_PERR 10
`define URX_FIFO_FULL 2'h2

`endif

// *** hdl/urx_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface urx_link_if;
  logic serial_line;
  modport rx_end (input serial_line);
  modport tx_end (output serial_line);
endinterface : urx_link_if
`default_nettype wire

// *** hdl/urx_pkg.sv ***
package urx_pkg;
  typedef enum logic [2:0] {
    urx_st_idle = 3'b000,
    urx_st_start = 3'b001,
    urx_st_data = 3'b010,
    urx_st_parity = 3'b011,
    urx_st_stop = 3'b100
  } urx_state_t;
endpackage : urx_pkg

// *** hdl/urx_receiver.sv ***
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "urx_consts.svh"
module urx_receiver
  import urx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`URX_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rxc_irq,
  output logic rxd_pin_claimed,
  urx_link_if.rx_end link
);

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  function automatic logic addr_known(input logic [`URX_ADDR_W-1:0] a);
    addr_known = (a == `URX_CTRL_OFF) || (a == `URX_STAT_OFF) ||
                 (a == `URX_DATA_OFF) || (a == `URX_BAUD_OFF);
  endfunction : addr_known

  logic [`URX_CTRL_W-1:0] ctrl_r;
  logic [15:0] baud_div_r;
  logic [15:0] div_cnt_r;
  logic tick;
  logic rxd_s1_r;
  logic rxd_s2_r;
  logic line_prev_r;
  urx_state_t state_r;
  logic [4:0] cnt_r;
  logic [4:0] idx;
  logic [4:0] spb;
  logic [4:0] mid;
  logic [3:0] bit_r;
  logic [1:0] votes_r;
  logic [7:0] shift_r;
  logic par_r;
  logic vote_now;
  logic maj;
  logic start_ok;
  logic frame_done;
  logic frame_take;
  logic en;
  logic [`URX_ENT_W-1:0] fifo_mem [0:1];
  logic rd_ptr_r;
  logic wr_ptr_r;
  logic [1:0] count_r;
  logic [`URX_ENT_W-1:0] head;
  logic rxc;
  logic pop;
  logic push;
  logic waiting_r;
  logic [9:0] hold_r;
  logic dor_pend_r;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] rd_val;

  ////////////////////////////////////////////////////////////////////////
  // register access

  assign en = ctrl_r[`URX_C_EN];
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign rxd_pin_claimed = en; // see RQ16

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `URX_CTRL_RST;
    end else if (wr_acc && paddr == `URX_CTRL_OFF) begin
      ctrl_r <= pwdata[`URX_CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_div_r <= `URX_BAUD_RST;
    end else if (wr_acc && paddr == `URX_BAUD_OFF) begin
      baud_div_r <= pwdata[15:0];
    end
  end

  // status writes land nowhere: error flags only follow the buffer
  always_comb begin // see RQ6
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `URX_CTRL_OFF: rd_val[`URX_CTRL_W-1:0] = ctrl_r;
      `URX_STAT_OFF: begin
        rd_val[`URX_S_RXC] = rxc; // see RQ1
        rd_val[`URX_S_FERR] = rxc & head[`URX_E_FERR]; // see RQ9
        rd_val[`URX_S_DOR] = rxc & head[`URX_E_DOR];
        rd_val[`URX_S_PERR] = rxc & head[`URX_E_PERR]; // see RQ14
      end
      `URX_DATA_OFF: rd_val[7:0] = rxc ? head[7:0] : 8'h00;
      `URX_BAUD_OFF: rd_val[15:0] = baud_div_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // captured in setup so the access phase sees the pre-pop entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= ~addr_known(paddr);
    end
  end

  // error flags deliberately have no path here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxc_irq <= 1'b0;
    end else begin
      // see RQ8
      rxc_irq <= ctrl_r[`URX_C_RCIRQ] & ctrl_r[`URX_C_GIE] & rxc; // see RQ3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line sampling

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
    end else begin
      rxd_s1_r <= link.serial_line;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  // one sample tick per divider wrap
  assign tick = (div_cnt_r == baud_div_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 16'h0000;
    end else if (tick) begin
      div_cnt_r <= 16'h0000;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_prev_r <= 1'b1;
    end else if (!en) begin
      line_prev_r <= 1'b1;
    end else if (tick) begin
      line_prev_r <= rxd_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // start detection and bit recovery

  assign spb = ctrl_r[`URX_C_DS] ? `URX_SPB_DBL : `URX_SPB_NORM; // see RQ18
  assign mid = ctrl_r[`URX_C_DS] ? `URX_MID_DBL : `URX_MID_NORM;
  assign idx = cnt_r + 5'h01;
  assign vote_now = tick && (state_r != urx_st_idle) &&
                    (idx == mid + 5'h02); // see RQ19
  assign maj = maj3(votes_r[1], votes_r[0], rxd_s2_r); // see RQ22
  assign start_ok = vote_now && (state_r == urx_st_start) && !maj;
  // stop bit ends the frame at its vote: early next start is legal
  assign frame_done = vote_now && (state_r == urx_st_stop); // see RQ10

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= urx_st_idle;
      cnt_r <= 5'h00;
      bit_r <= 4'h0;
    end else if (!en) begin
      state_r <= urx_st_idle; // see RQ15
      cnt_r <= 5'h00;
      bit_r <= 4'h0;
    end else if (tick) begin
      if (state_r != urx_st_idle) begin
        cnt_r <= (idx == spb) ? 5'h00 : idx;
      end
      unique case (state_r)
        urx_st_idle: begin
          if (line_prev_r && !rxd_s2_r) begin
            state_r <= urx_st_start; // see RQ21
            cnt_r <= 5'h01;
          end
        end
        urx_st_start: begin
          if (vote_now && maj) begin
            state_r <= urx_st_idle; // see RQ20
            cnt_r <= 5'h00;
          end else if (idx == spb) begin
            state_r <= urx_st_data;
            bit_r <= 4'h0;
          end
        end
        urx_st_data: begin
          if (idx == spb) begin
            bit_r <= bit_r + 4'h1;
            if (bit_r == `URX_LAST_BIT) begin
              state_r <= ctrl_r[`URX_C_PEN] ? urx_st_parity : urx_st_stop;
            end
          end
        end
        urx_st_parity: begin
          if (idx == spb) begin
            state_r <= urx_st_stop;
          end
        end
        urx_st_stop: begin
          if (vote_now) begin
            state_r <= urx_st_idle;
            cnt_r <= 5'h00;
          end
        end
        default: begin
          state_r <= urx_st_idle;
          cnt_r <= 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      votes_r <= 2'b11;
      shift_r <= 8'h00;
      par_r <= 1'b0;
    end else if (tick && state_r != urx_st_idle) begin
      if (idx == mid || idx == mid + 5'h01) begin
        votes_r <= {votes_r[0], rxd_s2_r};
      end
      if (vote_now && state_r == urx_st_data) begin
        shift_r <= {maj, shift_r[7:1]};
      end
      if (vote_now && state_r == urx_st_parity) begin
        par_r <= maj;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shifter hold stage and two-entry buffer

  assign rxc = (count_r != 2'h0);
  assign head = fifo_mem[rd_ptr_r];
  assign pop = rd_acc && (paddr == `URX_DATA_OFF) && rxc; // see RQ4
  assign push = waiting_r && (count_r != `URX_FIFO_FULL || pop);
  // a frame finishing while the shifter still waits is the lost one
  assign frame_take = frame_done && (!waiting_r || push);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waiting_r <= 1'b0;
      hold_r <= 10'h000;
    end else if (!en) begin
      waiting_r <= 1'b0;
    end else if (frame_take) begin
      waiting_r <= 1'b1;
      // even: data^par must be 0, odd: must be 1
      hold_r <= {ctrl_r[`URX_C_PEN] &
                 (^shift_r ^ par_r ^ ~ctrl_r[`URX_C_PODD] ^ 1'b1),
                 ~maj, shift_r}; // see RQ13 see RQ23 see RQ9
    end else if (push) begin
      waiting_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dor_pend_r <= 1'b0;
    end else if (!en) begin
      dor_pend_r <= 1'b0;
    end else if (start_ok && waiting_r && count_r == `URX_FIFO_FULL && !pop) begin
      dor_pend_r <= 1'b1; // see RQ11
    end else if (push) begin
      dor_pend_r <= 1'b0; // see RQ12
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      fifo_mem[wr_ptr_r] <= {hold_r[9], dor_pend_r, hold_r[8:0]}; // see RQ5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else if (!en) begin
      rd_ptr_r <= 1'b0; // see RQ2
      wr_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      rd_ptr_r <= rd_ptr_r ^ pop; // see RQ24
      wr_ptr_r <= wr_ptr_r ^ push;
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : urx_receiver
`default_nettype wire

// *** hdl/urx_transmitter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "urx_consts.svh"
module urx_transmitter
  import urx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic parity_enable_bit,
  input wire logic parity_odd_select,
  input wire logic stop_bit_count_select,
  input wire logic double_speed_select,
  input wire logic [15:0] baud_div,
  input wire logic force_bad_parity,
  input wire logic force_bad_stop,
  output logic tx_ready,
  urx_link_if.tx_end link
);

  logic [15:0] div_cnt_r;
  logic tick;
  logic [4:0] samp_r;
  logic [4:0] spb;
  logic [11:0] frame_r;
  logic [3:0] bits_left_r;
  logic line_r;
  logic par;
  logic bit_end;

  assign link.serial_line = line_r;
  assign tx_ready = (bits_left_r == 4'h0);
  assign spb = double_speed_select ? `URX_SPB_DBL : `URX_SPB_NORM;
  assign tick = (div_cnt_r == baud_div);
  assign bit_end = tick && (samp_r + 5'h01 == spb);
  assign par = ^tx_data ^ parity_odd_select ^ force_bad_parity;

  ////////////////////////////////////////////////////////////////////////
  // bit timing, restarted per frame so the start edge is clean

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 16'h0000;
      samp_r <= 5'h00;
    end else if (tx_ready || tick && bit_end) begin
      div_cnt_r <= 16'h0000;
      samp_r <= 5'h00;
    end else if (tick) begin
      div_cnt_r <= 16'h0000;
      samp_r <= samp_r + 5'h01;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame shifter, start bit first, data lsb first

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_r <= 12'hfff;
      bits_left_r <= 4'h0;
      line_r <= 1'b1;
    end else if (tx_ready) begin
      line_r <= 1'b1;
      if (tx_valid) begin
        frame_r <= parity_enable_bit ?
          {2'b11, ~force_bad_stop, par, tx_data} :
          {3'b111, ~force_bad_stop, tx_data};
        bits_left_r <= 4'ha + {3'b000, parity_enable_bit} +
                       {3'b000, stop_bit_count_select};
        line_r <= 1'b0;
      end
    end else if (bit_end) begin
      bits_left_r <= bits_left_r - 4'h1;
      line_r <= (bits_left_r == 4'h1) ? 1'b1 : frame_r[0];
      frame_r <= {1'b1, frame_r[11:1]};
    end
  end

endmodule : urx_transmitter
`default_nettype wire
